/* external_bus_unit.sv */
// External bus unit: maps data-space accesses beyond internal SRAM onto a
// multiplexed address/data bus with latch, read and write strobes.
// Assumes the CPU holds its request steady until accDone, and an external
// transparent latch on the shared pins.
module external_bus_unit
    import xbi_pkg::*;
#(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ctlAWrite,
    input wire logic ctlBWrite,
    input wire logic [7:0] ctlWData,
    output logic [7:0] ctlAReadback,
    output logic [7:0] ctlBReadback,
    input wire logic accReq,
    input wire logic accWrite,
    input wire logic [ADDR_WIDTH-1:0] accAddr,
    input wire logic [7:0] accWData,
    input wire logic nextIsData,
    output logic accExternal,
    output logic accDone,
    output logic accMiss,
    output logic [7:0] accRData,
    input wire logic [7:0] adPortOut,
    input wire logic [7:0] adPortDir,
    input wire logic [7:0] hiPortOut,
    input wire logic [7:0] hiPortDir,
    input wire logic [7:0] sharedAddrDataPinsIn,
    output logic [7:0] sharedAddrDataPinsOut,
    output logic [7:0] sharedAddrDataPinsOe,
    output logic [7:0] sharedAddrDataPullup,
    output logic [7:0] upperAddressPinsOut,
    output logic [7:0] upperAddressPinsOe,
    output logic latchStrobe,
    output logic readStrobe_n,
    output logic writeStrobe_n
);
    // Decode and pin logic serve a 16-bit data space only
    if (ADDR_WIDTH != 16) begin : gBadWidth
        $error("ADDR_WIDTH must be 16");
    end

    logic [7:0] ctlA, ctlB;
    logic busOn;
    logic keeperOn;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // two control registers
    xbi_ctl_regs u_regs (
        .clock(clock),
        .rst(rst),
        .ctlAWrite(ctlAWrite),
        .ctlBWrite(ctlBWrite),
        .ctlWData(ctlWData),
        .xbusControlA(ctlA),
        .xbusControlB(ctlB)
    );
    assign ctlAReadback = ctlA;
    assign ctlBReadback = ctlB;
    assign busOn = ctlA[CTLA_ON_BIT];
    assign keeperOn = ctlB[CTLB_KEEPER_BIT];

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Limit 0 puts the whole space in the upper sector
    function automatic logic inUpper(input logic [15:0] a,
                                     input logic [2:0] lim);
        logic [3:0] top;
        top = {1'b0, lim} + 4'h1;
        return (lim == 3'h0) || (a[15:12] >= top);
    endfunction

    logic isExt;
    logic [1:0] wsSel;
    assign isExt = accAddr > INTERNAL_TOP;
    always_comb begin
        if (inUpper(accAddr, ctlA[CTLA_LIMIT_LSB +: 3]))
            wsSel = ctlA[CTLA_UPPER_WS_LSB +: 2];
        else
            wsSel = ctlA[CTLA_LOWER_WS_LSB +: 2];
    end
    assign accExternal = busOn && isExt;
    assign accMiss = accReq && isExt && !busOn;

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    xbi_state_t state_q, state_d;
    logic [1:0] wait_q, wait_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] wdat_q, wdat_d;
    logic [7:0] rdat_q, rdat_d;
    logic wr_q, wr_d;
    logic ext_q, ext_d;
    logic ale_q, ale_d;
    logic [7:0] keep_q, keep_d;

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        wr_d = wr_q;
        ext_d = ext_q;
        ale_d = 1'b0;
        accDone = 1'b0;
        unique case (state_q)
            XBI_IDLE: begin
                // internal cycles still show address and latch
                if (accReq && busOn) begin
                    addr_d = accAddr;
                    wdat_d = accWData;
                    wr_d = accWrite;
                    ext_d = isExt;
                    wait_d = wsSel;
                    ale_d = 1'b1;
                    state_d = XBI_ADDR;
                end else if (accReq) begin
                    accDone = 1'b1;
                end
            end
            XBI_ADDR: begin
                // internal cycles skip the data phase
                state_d = ext_q ? XBI_DATA : XBI_DONE;
            end
            XBI_DATA: begin
                // one extra cycle; waits extend it
                if (wait_q != 2'h0) begin
                    wait_d = wait_q - 2'h1;
                    state_d = XBI_WAIT;
                end else begin
                    state_d = XBI_DONE;
                end
                if (!wr_q) rdat_d = sharedAddrDataPinsIn;
            end
            XBI_WAIT: begin
                if (wait_q != 2'h0) wait_d = wait_q - 2'h1;
                else state_d = XBI_DONE;
                if (!wr_q) rdat_d = sharedAddrDataPinsIn;
            end
            XBI_DONE: begin
                accDone = 1'b1;
                // trailing pulse only before a data access
                ale_d = nextIsData;
                state_d = XBI_IDLE;
            end
            default: state_d = XBI_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= XBI_IDLE;
            wait_q <= 2'h0;
            addr_q <= 16'h0000;
            wdat_q <= 8'h00;
            rdat_q <= 8'h00;
            wr_q <= 1'b0;
            ext_q <= 1'b0;
            ale_q <= 1'b0;
            keep_q <= 8'h00;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            wr_q <= wr_d;
            ext_q <= ext_d;
            ale_q <= ale_d;
            keep_q <= keep_d;
        end
    end
    assign accRData = rdat_q;

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    logic dataPhase, addrPhase, strobeOn;
    assign addrPhase = (state_q == XBI_ADDR) || ale_q;
    assign dataPhase = (state_q == XBI_DATA) || (state_q == XBI_WAIT);
    assign latchStrobe = busOn && ale_q;
    // active-low, width set by waits; only for external
    assign strobeOn = busOn && ext_q && dataPhase;
    assign readStrobe_n = !(strobeOn && !wr_q);
    assign writeStrobe_n = !(strobeOn && wr_q);

    logic [7:0] busMask;
    logic driveAd;
    // upper pin count from mask field, 0 releases none
    always_comb begin
        unique case (ctlB[CTLB_MASK_LSB +: 3])
            3'h1: busMask = 8'h7F;
            3'h2: busMask = 8'h3F;
            3'h3: busMask = 8'h1F;
            3'h4: busMask = 8'h0F;
            3'h5: busMask = 8'h07;
            3'h6: busMask = 8'h03;
            3'h7: busMask = 8'h00;
            default: busMask = 8'hFF;
        endcase
    end

    // drive write data, release on read
    assign driveAd = addrPhase || (dataPhase && wr_q) || (state_q == XBI_DONE
        && wr_q);

    always_comb begin
        keep_d = keep_q;
        if (busOn && driveAd) keep_d = sharedAddrDataPinsOut;
        else if (busOn && !driveAd) keep_d = sharedAddrDataPinsIn;
    end

    // address then data on shared pins; override or revert
    always_comb begin
        if (busOn) begin
            // keeper drives only while no read is under way
            sharedAddrDataPinsOe =
                (driveAd || (keeperOn && readStrobe_n)) ? 8'hFF : 8'h00;
            if (addrPhase)
                sharedAddrDataPinsOut = addr_q[7:0];
            else if (driveAd)
                sharedAddrDataPinsOut = wdat_q;
            else
                sharedAddrDataPinsOut = keep_q;
            // pull-ups from port bits while released
            sharedAddrDataPullup = driveAd ? 8'h00 : adPortOut;
        end else begin
            sharedAddrDataPinsOe = adPortDir;
            sharedAddrDataPinsOut = adPortOut;
            sharedAddrDataPullup = adPortOut & ~adPortDir;
        end
        for (int i = 0; i < 8; i++) begin
            if (busOn && busMask[i]) begin
                upperAddressPinsOe[i] = 1'b1;
                upperAddressPinsOut[i] = addr_q[8+i];
            end else begin
                upperAddressPinsOe[i] = hiPortDir[i];
                upperAddressPinsOut[i] = hiPortOut[i];
            end
        end
    end
endmodule

/* xbi_pkg.sv */
// Package for the external bus unit: control field layout, reset values,
// address boundary and wait-state timing.
// Assumes a 16-bit data space and an 8-bit shared address/data bus.
package xbi_pkg;

    // ------------------------------------------------------------------
    // Control register A fields
    // ------------------------------------------------------------------
    localparam int CTLA_ON_BIT = 7;
    localparam int CTLA_LIMIT_LSB = 4;
    localparam int CTLA_UPPER_WS_LSB = 2;
    localparam int CTLA_LOWER_WS_LSB = 0;
    localparam logic [7:0] CTLA_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Control register B fields
    // ------------------------------------------------------------------
    localparam int CTLB_KEEPER_BIT = 7;
    localparam int CTLB_MASK_LSB = 0;
    localparam logic [7:0] CTLB_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Address map and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] INTERNAL_TOP = 16'h21FF;
    localparam int BASE_EXTRA_CYCLES = 1;
    localparam logic [7:0] PORT_RESET = 8'h00;

    typedef enum logic [2:0] {
        XBI_IDLE,
        XBI_ADDR,
        XBI_DATA,
        XBI_WAIT,
        XBI_DONE
    } xbi_state_t;

endpackage

/* xbi_ctl_regs.sv */
// Holds the two bus control registers, written by the CPU side.
// Assumes writes arrive as single-cycle strobes on the system clock.
module xbi_ctl_regs
    import xbi_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ctlAWrite,
    input wire logic ctlBWrite,
    input wire logic [7:0] ctlWData,
    output logic [7:0] xbusControlA,
    output logic [7:0] xbusControlB
);
    logic [7:0] ctlA_q, ctlA_d;
    logic [7:0] ctlB_q, ctlB_d;

    always_comb begin
        ctlA_d = ctlAWrite ? ctlWData : ctlA_q;
        ctlB_d = ctlBWrite ? ctlWData : ctlB_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctlA_q <= CTLA_RESET;
            ctlB_q <= CTLB_RESET;
        end else begin
            ctlA_q <= ctlA_d;
            ctlB_q <= ctlB_d;
        end
    end

    assign xbusControlA = ctlA_q;
    assign xbusControlB = ctlB_q;
endmodule

/* xbi_bus_monitor.sv */
// Port checker for the external bus unit.
// Assumes it is bound to the unit and sees only the unit's ports.
module xbi_bus_monitor
    import xbi_pkg::*;
#(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic accReq,
    input wire logic [ADDR_WIDTH-1:0] accAddr,
    input wire logic [7:0] accWData,
    input wire logic accExternal,
    input wire logic accMiss,
    input wire logic [7:0] ctlAReadback,
    input wire logic [7:0] ctlBReadback,
    input wire logic [7:0] adPortOut,
    input wire logic [7:0] adPortDir,
    input wire logic [7:0] hiPortOut,
    input wire logic [7:0] hiPortDir,
    input wire logic [7:0] sharedAddrDataPinsIn,
    input wire logic [7:0] sharedAddrDataPinsOut,
    input wire logic [7:0] sharedAddrDataPinsOe,
    input wire logic [7:0] upperAddressPinsOut,
    input wire logic [7:0] upperAddressPinsOe,
    input wire logic latchStrobe,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Bus timing and pin ownership
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_NO_STROBE_INT:
        assert property (!accExternal |-> readStrobe_n && writeStrobe_n)
        else $error("Strobe active outside an external access");
    AST_NO_ALIAS:
        assert property (!ctlAReadback[7] && accReq && accAddr > INTERNAL_TOP
            |-> accMiss && !accExternal) else $error("High address aliased");
    AST_ALE_ADDR:
        assert property ($fell(latchStrobe) && !readStrobe_n
            |-> $past(sharedAddrDataPinsOut) == accAddr[7:0])
        else $error("Latch fell without low address on bus");
    AST_ALE_LOW:
        assert property (!readStrobe_n || !writeStrobe_n |-> !latchStrobe)
        else $error("Latch strobe high in data phase");
    AST_RD_FLOAT:
        assert property (!readStrobe_n |-> sharedAddrDataPinsOe == 8'h00)
        else $error("Read not released");
    AST_WR_DRIVE:
        assert property (!writeStrobe_n |-> sharedAddrDataPinsOe == 8'hFF
            && sharedAddrDataPinsOut == accWData)
        else $error("Bad write data");
    AST_OFF_PORT:
        assert property (!ctlAReadback[7]
            |-> sharedAddrDataPinsOut == adPortOut
            && sharedAddrDataPinsOe == adPortDir
            && upperAddressPinsOut == hiPortOut
            && upperAddressPinsOe == hiPortDir)
        else $error("Pins not following port when bus off");
    AST_UPPER:
        assert property (ctlAReadback[7] && ctlBReadback[2:0] == 3'h0
            && !readStrobe_n |-> upperAddressPinsOut == accAddr[15:8]
            && upperAddressPinsOe == 8'hFF) else $error("Bad high address");
    AST_KEEPER:
        assert property (ctlBReadback[7] && ctlAReadback[7]
            && $rose(readStrobe_n)
            |-> sharedAddrDataPinsOe == 8'hFF
            && sharedAddrDataPinsOut == $past(sharedAddrDataPinsIn))
        else $error("Keeper lost last value");
endmodule
bind external_bus_unit xbi_bus_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) uMon (.*);

/* xbi_sram_model.sv */
// Byte memory model behind a transparent address latch.
// Assumes the bench resolves the shared pins from all drivers.
module xbi_sram_model (
    input wire logic clock,
    input wire logic latchStrobe,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic [7:0] busLevel,
    output logic [7:0] memOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [7:0] lowAddr;
    logic [7:0] junk = 8'h5A;
    always_latch begin
        if (latchStrobe) lowAddr <= busLevel;
    end
    always @(posedge clock) begin
        junk <= ~junk;
        if (!writeStrobe_n) mem[lowAddr] <= busLevel;
    end
    // Released bus shows a changing pattern so stale data cannot pass
    assign memOut = readStrobe_n ? junk : mem[lowAddr];
endmodule

/* test_external_bus_unit.sv */
// Self-checking bench for the external bus unit and a memory model.
// Assumes the package, design, checker and model are compiled first.
module test_external_bus_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import xbi_pkg::*;
    logic clock = 1'b0, rst = 1'b1, ctlAWrite = 1'b0, ctlBWrite = 1'b0;
    logic accReq = 1'b0, accWrite = 1'b0, nextIsData = 1'b0;
    logic [15:0] accAddr = 16'h0000;
    logic [7:0] ctlWData = 8'h00, accWData = 8'h00, adPortOut = 8'h00;
    logic [7:0] adPortDir = 8'h00, hiPortOut = 8'h00, hiPortDir = 8'h00;
    logic [7:0] ctlAReadback, ctlBReadback, accRData, memOut;
    logic [7:0] sharedAddrDataPinsIn, sharedAddrDataPinsOut;
    logic [7:0] sharedAddrDataPinsOe, sharedAddrDataPullup;
    logic [7:0] upperAddressPinsOut, upperAddressPinsOe;
    logic accExternal, accDone, accMiss;
    // Classification seen as each access is presented: {external, miss}
    logic [1:0] accKind = 2'b00;
    logic latchStrobe, readStrobe_n, writeStrobe_n;
    int failures = 0;
    int totalChecks = 0;
    always #20 clock = ~clock;
    assign sharedAddrDataPinsIn =
        (sharedAddrDataPinsOe & sharedAddrDataPinsOut)
        | (~sharedAddrDataPinsOe & memOut);
    external_bus_unit DUT (.clock, .rst, .ctlAWrite, .ctlBWrite, .ctlWData,
        .ctlAReadback, .ctlBReadback, .accReq, .accWrite, .accAddr, .accWData,
        .nextIsData, .accExternal, .accDone, .accMiss, .accRData, .adPortOut,
        .adPortDir, .hiPortOut, .hiPortDir, .sharedAddrDataPinsIn,
        .sharedAddrDataPinsOut, .sharedAddrDataPinsOe, .sharedAddrDataPullup,
        .upperAddressPinsOut, .upperAddressPinsOe, .latchStrobe,
        .readStrobe_n, .writeStrobe_n);
    xbi_sram_model uMem (.clock, .latchStrobe, .readStrobe_n, .writeStrobe_n,
        .busLevel(sharedAddrDataPinsIn), .memOut);
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        totalChecks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic ctl(input logic b, input logic [7:0] v);
        @(negedge clock);
        ctlAWrite = !b;
        ctlBWrite = b;
        ctlWData = v;
        @(negedge clock);
        ctlAWrite = 1'b0;
        ctlBWrite = 1'b0;
    endtask
    // Cycles counted from the taking edge; trailing latch looked at twice
    task automatic acc(input logic wr, input logic [15:0] a,
            input logic [7:0] d, input logic nd, output logic [7:0] rd,
            output int n, output logic lp);
        @(negedge clock);
        accReq = 1'b1;
        accWrite = wr;
        accAddr = a;
        accWData = d;
        nextIsData = nd;
        n = 0;
        #1;
        accKind = {accExternal, accMiss};
        while (accDone !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        rd = accRData;
        lp = latchStrobe;
        @(negedge clock);
        accReq = 1'b0;
        @(posedge clock);
        #1;
        lp = lp | latchStrobe;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk(ctlAReadback, CTLA_RESET);
        chk(ctlBReadback, CTLB_RESET);
        chk({6'h00, readStrobe_n, writeStrobe_n}, 8'h03);
        $display("t_reset done");
    endtask
    task automatic t_off();
        logic [7:0] rd;
        int n;
        logic lp;
        @(negedge clock);
        adPortOut = 8'h3C;
        adPortDir = 8'hF0;
        hiPortDir = 8'h0F;
        @(negedge clock);
        chk(sharedAddrDataPinsOe, 8'hF0);
        chk(upperAddressPinsOe, 8'h0F);
        chk(sharedAddrDataPullup, 8'h0C);
        acc(1'b0, 16'h8000, 8'h00, 1'b0, rd, n, lp);
        chk(8'(n), 8'h00);
        chk({6'h00, accKind}, 8'h01);
        $display("t_off done");
    endtask
    task automatic t_wait();
        logic [7:0] rd;
        int n;
        logic lp;
        for (int w = 0; w < 4; w++) begin
            ctl(1'b0, 8'h80 | 8'(w << 2));
            chk(ctlAReadback, 8'h80 | 8'(w << 2));
            acc(1'b1, 16'h3010 + 16'(w), 8'h50 + 8'(w), 1'b0, rd, n, lp);
            chk(8'(n), 8'(3 + w));
            chk({6'h00, accKind}, 8'h02);
            chk({7'h00, lp}, 8'h00);
            acc(1'b0, 16'h3010 + 16'(w), 8'h00, 1'b1, rd, n, lp);
            chk(rd, 8'h50 + 8'(w));
            chk({7'h00, lp}, 8'h01);
        end
        $display("t_wait done");
    endtask
    task automatic t_sector();
        logic [7:0] rd;
        int n;
        logic lp;
        ctl(1'b0, 8'hA3);
        acc(1'b1, 16'h2420, 8'h77, 1'b0, rd, n, lp);
        chk(8'(n), 8'h06);
        acc(1'b1, 16'h3430, 8'h66, 1'b0, rd, n, lp);
        chk(8'(n), 8'h03);
        acc(1'b0, 16'h0100, 8'h00, 1'b0, rd, n, lp);
        chk(8'(n), 8'h02);
        chk({6'h00, accKind}, 8'h00);
        $display("t_sector done");
    endtask
    task automatic t_pins();
        logic [7:0] rd;
        int n;
        logic lp;
        ctl(1'b1, 8'h07);
        chk(upperAddressPinsOe, hiPortDir);
        chk(upperAddressPinsOut, 8'h00);
        chk(sharedAddrDataPullup, 8'h3C);
        ctl(1'b1, 8'h80);
        acc(1'b0, 16'h3010, 8'h00, 1'b0, rd, n, lp);
        chk(rd, 8'h50);
        chk(sharedAddrDataPinsOe, 8'hFF);
        chk(sharedAddrDataPinsOut, 8'h50);
        ctl(1'b1, 8'h00);
        $display("t_pins done");
    endtask
    task automatic results();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_off();
        t_wait();
        t_sector();
        t_pins();
        adPortOut = 8'h00;
        @(negedge clock);
        chk(sharedAddrDataPullup, 8'h00);
        results();
    end
    // Whole run needs under a hundred cycles; this allows 2500 cycles
    initial begin
        #100us;
        failures++;
        results();
    end
endmodule
